// file: common/ppp_pkg.sv
package ppp_pkg;
    localparam int PPP_CLK_MHZ = 10;
    localparam int PPP_CLK_PERIOD_NS = 100;
    // program pulse width in microseconds (0.1 ms)
    localparam int PPP_PULSE_US = 100;
    localparam int PPP_PULSE_CYC =
        (PPP_PULSE_US * 1000) / PPP_CLK_PERIOD_NS;
    localparam int PPP_ADDR_W = 17;
    localparam int PPP_DATA_W = 8;
    localparam int PPP_PAGE_BYTES = 4;
    localparam int PPP_MAX_TRIES = 10;
    localparam logic [16:0] PPP_LAST_ADDR = 17'h07fff;
    localparam int PPP_SETUP_CYC = 2;
    localparam int PPP_CNT_W = 16;

    typedef enum logic [1:0] {
        PPP_OP_READ,
        PPP_OP_BYTE,
        PPP_OP_PAGE
    } ppp_op_t;
endpackage

// file: common/ppp_pins_if.sv
`timescale 1ns/1ps
interface ppp_pins_if;
    logic rst_n;
    logic vpp_hi;
    logic vpp_on;
    logic select_n;
    logic strobe_n;
    logic program_pulse_n;
    logic [16:0] address_lines;
    logic [7:0] data_out;
    logic data_oe;
    logic [7:0] data_in;
    modport ctrl (
        output rst_n, vpp_hi, vpp_on, select_n, strobe_n,
        output program_pulse_n, address_lines, data_out, data_oe,
        input data_in
    );
    modport drv (
        input rst_n, vpp_hi, vpp_on, select_n, strobe_n,
        input program_pulse_n, address_lines, data_out, data_oe,
        output data_in
    );
endinterface

// file: logic/ppp_pin_drv.sv
`timescale 1ns/1ps
module ppp_pin_drv (
    ppp_pins_if.drv pins,
    output logic o_rst_b,
    output logic o_vpp_hi,
    output logic o_vpp_on,
    output logic o_select_n,
    output logic o_strobe_n,
    output logic o_program_pulse_n,
    output logic [16:0] o_address_lines,
    output logic [7:0] o_data_bus,
    output logic o_data_bus_oe,
    input wire logic [7:0] i_data_bus
);
    assign o_rst_b = pins.rst_n;
    assign o_vpp_hi = pins.vpp_hi;
    assign o_vpp_on = pins.vpp_on;
    assign o_select_n = pins.select_n;
    assign o_strobe_n = pins.strobe_n;
    assign o_program_pulse_n = pins.program_pulse_n;
    assign o_address_lines = pins.address_lines;
    assign o_data_bus = pins.data_out;
    // the device drives only with select and strobe both low; page latch
    // holds strobe low with select high and still needs our data
    assign o_data_bus_oe = pins.data_oe & (pins.strobe_n | pins.select_n);
    assign pins.data_in = i_data_bus;
endmodule

// file: logic/ppp_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - programming mode: reset low with programming voltage at read or high level
// - page write starts: select high, strobe low, pulse high, high voltage
// - after four bytes, one 0.1 ms low pulse, select and strobe high
// - verify by select low, strobe low, reading stored bytes
// - on mismatch repeat write and verify, at most 10 times total
// - read level: select and strobe low give addressed byte
// - shared bus: only chosen device gets its strobe asserted
// - program only addresses 0000 to 7fff
// - byte write: select low, strobe high, 0.1 ms low pulse
// - high voltage, select low, pulse high, strobe low verifies byte
module ppp_ctrl
    import ppp_pkg::*;
#(
    parameter int PULSE_CYC = ppp_pkg::PPP_PULSE_CYC,
    parameter int MAX_TRIES = ppp_pkg::PPP_MAX_TRIES
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire ppp_pkg::ppp_op_t i_op,
    input wire logic [16:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [7:0] i_data_bus,
    output logic o_busy,
    output logic o_done,
    output logic o_error,
    output logic [7:0] o_rdata,
    output logic o_rst_b,
    output logic o_vpp_hi,
    output logic o_vpp_on,
    output logic o_select_n,
    output logic o_strobe_n,
    output logic o_program_pulse_n,
    output logic [16:0] o_address_lines,
    output logic [7:0] o_data_bus,
    output logic o_data_bus_oe
);
    import ppp_pkg::*;

    typedef enum logic [2:0] {
        PPP_IDLE, PPP_LATCH, PPP_PULSE, PPP_VERIFY, PPP_READ, PPP_END
    } ppp_state_t;

    ppp_pins_if pins();

    ppp_pin_drv u_drv (
        .pins(pins),
        .o_rst_b(o_rst_b),
        .o_vpp_hi(o_vpp_hi),
        .o_vpp_on(o_vpp_on),
        .o_select_n(o_select_n),
        .o_strobe_n(o_strobe_n),
        .o_program_pulse_n(o_program_pulse_n),
        .o_address_lines(o_address_lines),
        .o_data_bus(o_data_bus),
        .o_data_bus_oe(o_data_bus_oe),
        .i_data_bus(i_data_bus)
    );

    ppp_state_t state_ff;
    ppp_op_t op_ff;
    logic [16:0] base_ff;
    logic [31:0] wdata_ff;
    logic [1:0] idx_ff;
    logic [1:0] phase_ff;
    logic [PPP_CNT_W-1:0] cnt_ff;
    logic [3:0] tries_ff;
    logic mismatch_ff;
    logic done_ff;
    logic error_ff;
    logic [7:0] rdata_ff;
    logic sel_n_ff;
    logic stb_n_ff;
    logic pgm_n_ff;
    logic oe_ff;
    logic [7:0] dout_ff;
    logic [1:0] last_idx;
    logic [7:0] cur_byte;
    logic addr_ok;

    assign last_idx = (op_ff == PPP_OP_PAGE) ? 2'h3 : 2'h0;
    assign cur_byte = wdata_ff[{idx_ff, 3'h0} +: 8];
    // page runs must not cross the top of the array
    assign addr_ok = (i_op == PPP_OP_PAGE) ?
        ({1'b0, i_addr} + 18'h3 <= {1'b0, PPP_LAST_ADDR}) :
        (i_op == PPP_OP_READ) || (i_addr <= PPP_LAST_ADDR);

    assign pins.rst_n = 1'b0;
    assign pins.vpp_on = 1'b1;
    // read level kept through the end cycle of a read as well
    assign pins.vpp_hi = (op_ff != PPP_OP_READ);
    assign pins.select_n = sel_n_ff;
    assign pins.strobe_n = stb_n_ff;
    assign pins.program_pulse_n = pgm_n_ff;
    assign pins.address_lines = base_ff + {15'h0, idx_ff};
    assign pins.data_out = dout_ff;
    assign pins.data_oe = oe_ff;

    assign o_busy = (state_ff != PPP_IDLE);
    assign o_done = done_ff;
    assign o_error = error_ff;
    assign o_rdata = rdata_ff;

    // sequencer: state, byte index and phase counter
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_ff <= PPP_IDLE;
            op_ff <= PPP_OP_READ;
            base_ff <= '0;
            wdata_ff <= '0;
            idx_ff <= '0;
            phase_ff <= '0;
            cnt_ff <= '0;
            tries_ff <= '0;
            mismatch_ff <= 1'b0;
        end else begin
            case (state_ff)
                PPP_IDLE: begin
                    idx_ff <= '0;
                    phase_ff <= '0;
                    cnt_ff <= '0;
                    tries_ff <= '0;
                    mismatch_ff <= 1'b0;
                    if (i_start && addr_ok) begin
                        op_ff <= i_op;
                        base_ff <= i_addr;
                        wdata_ff <= i_wdata;
                        state_ff <= (i_op == PPP_OP_READ) ? PPP_READ :
                            (i_op == PPP_OP_PAGE) ? PPP_LATCH : PPP_PULSE;
                    end else if (i_start) begin
                        state_ff <= PPP_END;
                    end
                end
                PPP_LATCH: begin
                    // each byte held for setup, strobe-low window, hold
                    if (cnt_ff == PPP_CNT_W'(PPP_SETUP_CYC)) begin
                        cnt_ff <= '0;
                        if (phase_ff == 2'h2) begin
                            phase_ff <= '0;
                            if (idx_ff == 2'h3) begin
                                idx_ff <= '0;
                                state_ff <= PPP_PULSE;
                            end else begin
                                idx_ff <= idx_ff + 2'h1;
                            end
                        end else begin
                            phase_ff <= phase_ff + 2'h1;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                PPP_PULSE: begin
                    if (phase_ff == 2'h0) begin
                        if (cnt_ff == PPP_CNT_W'(PPP_SETUP_CYC)) begin
                            cnt_ff <= '0;
                            phase_ff <= 2'h1;
                        end else begin
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                    end else if (phase_ff == 2'h1) begin
                        if (cnt_ff == PPP_CNT_W'(PULSE_CYC - 1)) begin
                            cnt_ff <= '0;
                            phase_ff <= 2'h2;
                        end else begin
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                    end else begin
                        if (cnt_ff == PPP_CNT_W'(PPP_SETUP_CYC)) begin
                            cnt_ff <= '0;
                            phase_ff <= '0;
                            tries_ff <= tries_ff + 4'h1;
                            mismatch_ff <= 1'b0;
                            state_ff <= PPP_VERIFY;
                        end else begin
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                    end
                end
                PPP_VERIFY, PPP_READ: begin
                    if (cnt_ff == PPP_CNT_W'(PPP_SETUP_CYC)) begin
                        cnt_ff <= '0;
                        if (cur_byte != i_data_bus) begin
                            mismatch_ff <= 1'b1;
                        end
                        if (state_ff == PPP_READ) begin
                            state_ff <= PPP_END;
                        end else if (idx_ff != last_idx) begin
                            idx_ff <= idx_ff + 2'h1;
                        end else if (mismatch_ff ||
                                cur_byte != i_data_bus) begin
                            idx_ff <= '0;
                            state_ff <= (tries_ff >= 4'(MAX_TRIES)) ?
                                PPP_END :
                                (op_ff == PPP_OP_PAGE) ? PPP_LATCH :
                                PPP_PULSE;
                        end else begin
                            state_ff <= PPP_END;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                PPP_END: begin
                    state_ff <= PPP_IDLE;
                end
                default: begin
                    state_ff <= PPP_IDLE;
                end
            endcase
        end
    end

    // pin levels registered from the state, so they are glitch-free
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sel_n_ff <= 1'b1;
            stb_n_ff <= 1'b1;
            pgm_n_ff <= 1'b1;
            oe_ff <= 1'b0;
            dout_ff <= '0;
        end else begin
            sel_n_ff <= 1'b1;
            stb_n_ff <= 1'b1;
            pgm_n_ff <= 1'b1;
            oe_ff <= 1'b0;
            dout_ff <= cur_byte;
            case (state_ff)
                PPP_LATCH: begin
                    stb_n_ff <= (phase_ff != 2'h1);
                    oe_ff <= 1'b1;
                end
                PPP_PULSE: begin
                    sel_n_ff <= (op_ff == PPP_OP_PAGE);
                    pgm_n_ff <= (phase_ff != 2'h1);
                    oe_ff <= (op_ff == PPP_OP_BYTE);
                end
                PPP_VERIFY, PPP_READ: begin
                    sel_n_ff <= 1'b0;
                    stb_n_ff <= 1'b0;
                end
                default: begin
                    oe_ff <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            done_ff <= 1'b0;
            error_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            done_ff <= (state_ff == PPP_END);
            if (state_ff == PPP_IDLE && i_start) begin
                error_ff <= !addr_ok;
            end else if (state_ff == PPP_VERIFY && tries_ff >= 4'(MAX_TRIES)
                    && cnt_ff == PPP_CNT_W'(PPP_SETUP_CYC)
                    && idx_ff == last_idx
                    && (mismatch_ff || cur_byte != i_data_bus)) begin
                error_ff <= 1'b1;
            end
            if (state_ff == PPP_READ && cnt_ff == PPP_CNT_W'(PPP_SETUP_CYC))
            begin
                rdata_ff <= i_data_bus;
            end
        end
    end

    sequence s_pulse_low;
        !o_program_pulse_n [*8];
    endsequence

    AST_PULSE_SEL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !o_program_pulse_n |-> o_strobe_n && o_vpp_hi)
        else $error("pulse without strobe high or high voltage");
    AST_PULSE_WIDTH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_program_pulse_n) |-> s_pulse_low)
        else $error("program pulse too short");
    AST_NO_CONTENTION: assert property (@(posedge i_clk)
        disable iff (!i_rst_b) (!o_strobe_n && !o_select_n) |-> !oe_ff)
        else $error("bus driven in verify or read");
    AST_MODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_busy |-> !o_rst_b && o_vpp_on)
        else $error("mode pins wrong");
    AST_LATCH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_ff == PPP_LATCH && phase_ff != 2'h0 && !o_strobe_n) |->
        o_select_n && o_program_pulse_n && o_data_bus_oe)
        else $error("latch pins wrong");
    AST_RANGE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !o_program_pulse_n |-> o_address_lines <= PPP_LAST_ADDR)
        else $error("write beyond top address");
    AST_TRIES: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        tries_ff <= 4'(MAX_TRIES))
        else $error("too many write attempts");
    AST_VERIFY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!o_strobe_n && !o_select_n) |-> o_program_pulse_n)
        else $error("verify with pulse low");
    AST_READ_DONE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_ff == PPP_IDLE && i_start && i_op == PPP_OP_READ) |->
        ##[4:6] o_done)
        else $error("read took wrong time");
endmodule

// file: verif/ppp_prom_model.sv
`timescale 1ns/1ps
module ppp_prom_model #(
    parameter int MIN_NS = 800
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_vpp_on,
    input wire logic i_vpp_hi,
    input wire logic i_select_n,
    input wire logic i_strobe_n,
    input wire logic i_program_pulse_n,
    input wire logic [16:0] i_address_lines,
    input wire logic [7:0] i_ctrl_data,
    input wire logic i_ctrl_oe,
    output logic [7:0] o_data_bus,
    output logic o_clash,
    output logic o_short_pulse
);
    logic [7:0] mem [0:32767];
    logic [7:0] page [0:3];
    logic [16:0] page_addr;
    logic [16:0] byte_addr;
    logic [7:0] byte_val;
    logic [7:0] last_ff;
    logic prog_mode;
    logic drive;
    realtime fall_t;
    int skip = 0;
    int pulses = 0;
    assign prog_mode = !i_rst_b && i_vpp_on;
    assign drive = prog_mode && !i_select_n && !i_strobe_n &&
        (i_program_pulse_n || !i_vpp_hi);
    // a released bus shows a changing pattern, never the last value
    assign o_data_bus = i_ctrl_oe ? i_ctrl_data :
        drive ? mem[i_address_lines[14:0]] : ~last_ff;
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'hff;
        end
        last_ff = 8'h00;
        o_clash = 1'b0;
        o_short_pulse = 1'b0;
    end
    always @(posedge i_clk) begin
        last_ff <= o_data_bus;
        if (i_ctrl_oe && drive) begin
            o_clash <= 1'b1;
        end
    end
    always @(posedge i_strobe_n) begin
        if (prog_mode && i_vpp_hi && i_select_n && i_program_pulse_n) begin
            page[i_address_lines[1:0]] = o_data_bus;
            page_addr = i_address_lines;
        end
    end
    always @(negedge i_program_pulse_n) begin
        fall_t = $realtime;
        byte_val = o_data_bus;
        byte_addr = i_address_lines;
    end
    // skip lets a scenario make the cells refuse a number of pulses
    always @(posedge i_program_pulse_n) begin
        if (prog_mode && i_vpp_hi && i_strobe_n) begin
            pulses++;
            if ($realtime - fall_t < MIN_NS) begin
                o_short_pulse = 1'b1;
            end else if (skip > 0) begin
                skip--;
            end else if (i_select_n) begin
                for (int k = 0; k < 4; k++) begin
                    mem[{page_addr[14:2], k[1:0]}] &= page[k];
                end
            end else begin
                mem[byte_addr[14:0]] &= byte_val;
            end
        end
    end
endmodule

// file: verif/prom_programming_port_tb.sv
`timescale 1ns/1ps
module prom_programming_port_tb;
    import ppp_pkg::*;
    localparam int PULSE = 8;
    logic i_clk, i_rst_b, i_start;
    ppp_op_t i_op;
    logic [16:0] i_addr, o_address_lines;
    logic [31:0] i_wdata;
    logic [7:0] bus, o_rdata, o_data_bus;
    logic o_busy, o_done, o_error, o_rst_b, o_vpp_hi, o_vpp_on;
    logic o_select_n, o_strobe_n, o_program_pulse_n, o_data_bus_oe;
    logic clash, short_pulse;
    logic [2:0] moved;
    int bad_count = 0;
    int comparisons = 0;
    int cyc;

    ppp_ctrl #(.PULSE_CYC(PULSE), .MAX_TRIES(PPP_MAX_TRIES)) uut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
        .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_data_bus(bus), .o_busy(o_busy), .o_done(o_done),
        .o_error(o_error), .o_rdata(o_rdata), .o_rst_b(o_rst_b),
        .o_vpp_hi(o_vpp_hi), .o_vpp_on(o_vpp_on),
        .o_select_n(o_select_n), .o_strobe_n(o_strobe_n),
        .o_program_pulse_n(o_program_pulse_n),
        .o_address_lines(o_address_lines), .o_data_bus(o_data_bus),
        .o_data_bus_oe(o_data_bus_oe));

    ppp_prom_model #(.MIN_NS(PULSE * PPP_CLK_PERIOD_NS)) dev (
        .i_clk(i_clk), .i_rst_b(o_rst_b), .i_vpp_on(o_vpp_on),
        .i_vpp_hi(o_vpp_hi), .i_select_n(o_select_n),
        .i_strobe_n(o_strobe_n), .i_program_pulse_n(o_program_pulse_n),
        .i_address_lines(o_address_lines), .i_ctrl_data(o_data_bus),
        .i_ctrl_oe(o_data_bus_oe), .o_data_bus(bus), .o_clash(clash),
        .o_short_pulse(short_pulse));

    task automatic test_done();
        $display("checks %0d errors %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // entered just after an edge; returns after the done edge
    task automatic run(input ppp_op_t op, input logic [16:0] a,
                       input logic [31:0] d);
        i_op = op;
        i_addr = a;
        i_wdata = d;
        i_start = 1'b1;
        cyc = 0;
        moved = 3'b000;
        @(posedge i_clk);
        #1 i_start = 1'b0;
        while (o_done !== 1'b1) begin
            @(posedge i_clk);
            #1 cyc++;
            moved |= ~{o_select_n, o_strobe_n, o_program_pulse_n};
            if (cyc > 5000) begin
                check("done_wait", 32'h0, 32'h1);
                test_done();
            end
        end
    endtask

    task automatic read_chk(input logic [16:0] a, input logic [7:0] exp);
        run(PPP_OP_READ, a, 32'h0);
        check("read_cycles", cyc, 32'h4);
        check("read_data", o_rdata, {24'h0, exp});
        check("read_level", o_vpp_hi, 32'h0);
    endtask

    task automatic t_idle();
        check("idle_pins", {o_rst_b, o_vpp_on, o_select_n, o_strobe_n,
            o_program_pulse_n, o_data_bus_oe, o_busy, o_done},
            32'h78);
        read_chk(17'h00100, 8'hff);
    endtask

    task automatic t_byte(input logic [16:0] a, input logic [7:0] d);
        run(PPP_OP_BYTE, a, {24'h0, d});
        check("byte_err", o_error, 32'h0);
        read_chk(a, d);
    endtask

    task automatic t_page(input logic [16:0] a, input logic [31:0] d,
                          input int fails);
        dev.skip = fails;
        dev.pulses = 0;
        run(PPP_OP_PAGE, a, d);
        check("page_err", o_error, 32'h0);
        check("page_pulses", dev.pulses, fails + 1);
        for (int k = 0; k < 4; k++) begin
            read_chk(17'(a + k), d[8*k +: 8]);
        end
    endtask

    task automatic t_give_up();
        dev.skip = 50;
        dev.pulses = 0;
        run(PPP_OP_PAGE, 17'h07ffc, 32'h01020304);
        check("tries_err", o_error, 32'h1);
        check("tries_count", dev.pulses, PPP_MAX_TRIES);
        dev.skip = 0;
        read_chk(17'h07ffc, 8'hff);
    endtask

    task automatic t_range();
        run(PPP_OP_BYTE, 17'h08000, 32'h0);
        check("range_byte_err", o_error, 32'h1);
        check("range_cycles", cyc, 32'h1);
        check("range_pins", moved, 32'h0);
        run(PPP_OP_PAGE, 17'h07ffe, 32'h0);
        check("range_page_err", o_error, 32'h1);
        check("range_pins", moved, 32'h0);
        read_chk(17'h07fff, 8'ha5);
        check("range_clear", o_error, 32'h0);
    endtask

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial begin
        i_rst_b = 1'b0;
        i_start = 1'b0;
        i_op = PPP_OP_READ;
        i_addr = 17'h00000;
        i_wdata = 32'h0;
        repeat (20) @(posedge i_clk);
        #1 i_rst_b = 1'b1;
        @(posedge i_clk);
        #1 t_idle();
        t_byte(17'h00010, 8'h5a);
        t_byte(17'h07fff, 8'ha5);
        t_page(17'h00020, 32'h44332211, 0);
        t_page(17'h00040, 32'h8c7b6a59, 2);
        t_give_up();
        t_range();
        check("bus_clash", clash, 32'h0);
        check("pulse_width", short_pulse, 32'h0);
        test_done();
    end
endmodule
